// ===== hdl/fcb_pkg.sv
// Notes on behaviour
// [R1] synchronous two-way bus, control traffic only
// [R2] controller is sole master, boards slaves
// [R3] address is 6-bit device, 10-bit page
// [R4] master drives 20 MHz valid strobe
// [R5] active-low address strobe marks valid address
// [R6] active-low write select marks writes
// [R7] active-low page transfer select from master
// [R8] active-low refresh strobe from master
// [R9] 16-bit data, separate upper/lower byte strobes
// [R10] addressed slave drives active-low acknowledge
// [R11] typical transaction takes eight 40 MHz cycles
// [R12] transactions read and write slave registers
// [R13] timing from common 40 MHz clock, reset; code times from the 250 MHz core clock divided by 6
// [R14] unselected slave releases data and acknowledge
// [R15] master holds address/controls until ack/window end
package fcb_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int FCB_DATA_W = 16;  // data lanes
    localparam int FCB_DEV_W  = 6;   // device select width
    localparam int FCB_PAGE_W = 10;  // page address width
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int FCB_CLK_MHZ     = 250;   // core clock rate
    localparam int FCB_SYS_MHZ     = 40;    // bus system clock
    localparam int FCB_STROBE_MHZ  = 20;    // valid strobe rate
    localparam int FCB_XFER_NS     = 200;   // typical transaction
    // core cycles per 40 MHz tick, rounded down, 6 at 250 MHz
    localparam int FCB_SYS_DIV = FCB_CLK_MHZ / FCB_SYS_MHZ;
    // window in 40 MHz ticks: 200 ns * 40 MHz
    localparam int FCB_XFER_TICKS = FCB_XFER_NS * FCB_SYS_MHZ / 1000;
    localparam int FCB_CNT_W = 4;           // tick counter width
    localparam logic [FCB_DEV_W-1:0] FCB_RST_DEV = 6'h00; // reset id
endpackage

// ===== hdl/fcb_bus_if.sv
`timescale 1ns/1ps
interface fcb_bus_if;
    import fcb_pkg::*;
    logic [FCB_DATA_W-1:0] m_data;        // master data out
    logic                  m_data_oe;     // master drives data
    logic [FCB_DATA_W-1:0] s_data;        // slave data out
    logic                  s_data_oe;     // slave drives data
    logic [FCB_DATA_W-1:0] ctl_bus_data;  // resolved data level
    logic [FCB_DEV_W-1:0]  ctl_bus_device_select;
    logic [FCB_PAGE_W-1:0] ctl_bus_page_address;
    logic                  ctl_bus_valid_strobe;
    logic                  ctl_bus_addr_strobe_n;
    logic                  ctl_bus_write_sel_n;
    logic                  ctl_bus_page_xfer_n;
    logic                  ctl_bus_refresh_n;
    logic                  ctl_bus_upper_byte_n;
    logic                  ctl_bus_lower_byte_n;
    logic                  s_ack_n;       // slave ack level
    logic                  s_ack_oe;      // slave drives ack
    logic                  ctl_bus_ack_n; // resolved ack, pulled up
    // resolution of the shared wires
    assign ctl_bus_data  = m_data_oe ? m_data :
                           (s_data_oe ? s_data : '1);
    assign ctl_bus_ack_n = s_ack_oe ? s_ack_n : 1'b1;
    modport master (
        output m_data, m_data_oe, ctl_bus_device_select,
        output ctl_bus_page_address, ctl_bus_valid_strobe,
        output ctl_bus_addr_strobe_n, ctl_bus_write_sel_n,
        output ctl_bus_page_xfer_n, ctl_bus_refresh_n,
        output ctl_bus_upper_byte_n, ctl_bus_lower_byte_n,
        input  ctl_bus_data, ctl_bus_ack_n
    );
    modport slave (
        output s_data, s_data_oe, s_ack_n, s_ack_oe,
        input  ctl_bus_data, ctl_bus_device_select,
        input  ctl_bus_page_address, ctl_bus_valid_strobe,
        input  ctl_bus_addr_strobe_n, ctl_bus_write_sel_n,
        input  ctl_bus_page_xfer_n, ctl_bus_refresh_n,
        input  ctl_bus_upper_byte_n, ctl_bus_lower_byte_n
    );
endinterface

// ===== hdl/fcb_master.sv
`timescale 1ns/1ps
module fcb_master
    import fcb_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  rst_b_in,
    fcb_bus_if.master                  bus,
    input  wire logic                  req_valid_in,
    output logic                       req_ready_out,
    input  wire logic                  req_write_in,
    input  wire logic [FCB_DEV_W-1:0]  req_dev_in,
    input  wire logic [FCB_PAGE_W-1:0] req_page_in,
    input  wire logic [FCB_DATA_W-1:0] req_wdata_in,
    input  wire logic [1:0]            req_bytes_in,
    input  wire logic                  page_xfer_in,
    input  wire logic                  refresh_in,
    output logic                       done_out,
    output logic                       timeout_out,
    output logic [FCB_DATA_W-1:0]      rdata_out
);
    // ------------------------------------------------------------
    // tick divider: 40 MHz enable and 20 MHz strobe
    // ------------------------------------------------------------
    logic [3:0]           div_r, div_nxt;     // core cycle count
    logic                 tick;               // one 40 MHz tick
    logic                 vstb_r, vstb_nxt;   // valid strobe level
    always_comb begin
        tick     = (div_r == 4'(FCB_SYS_DIV - 1));
        div_nxt  = tick ? 4'h0 : div_r + 4'h1;
        vstb_nxt = tick ? ~vstb_r : vstb_r;   // [R4]
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin                      // [R13]
            div_r  <= 4'h0;
            vstb_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            vstb_r <= vstb_nxt;
        end
    end
    // ------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {FCB_IDLE, FCB_ADDR, FCB_WAIT} fcb_mst_t;
    fcb_mst_t              st_r, st_nxt;       // state
    logic [FCB_CNT_W-1:0]  cnt_r, cnt_nxt;     // ticks in window
    logic                  wr_r, wr_nxt;       // latched write
    logic [FCB_DEV_W-1:0]  dev_r, dev_nxt;     // latched device
    logic [FCB_PAGE_W-1:0] page_r, page_nxt;   // latched page
    logic [FCB_DATA_W-1:0] wd_r, wd_nxt;       // latched data
    logic [1:0]            by_r, by_nxt;       // byte enables
    logic [FCB_DATA_W-1:0] rd_r, rd_nxt;       // read data
    logic                  dn_r, dn_nxt;       // done pulse
    logic                  to_r, to_nxt;       // timeout pulse
    logic                  pg_r, pg_nxt;       // page transfer
    logic                  rf_r, rf_nxt;       // refresh
    logic                  a1, a2, ack_s;      // ack synchroniser
    logic [FCB_DATA_W-1:0] d1, d2;             // data synchroniser
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            a1 <= 1'b1;
            a2 <= 1'b1;
            d1 <= '0;
            d2 <= '0;
        end else begin
            a1 <= bus.ctl_bus_ack_n;
            a2 <= a1;
            d1 <= bus.ctl_bus_data;
            d2 <= d1;
        end
    end
    assign ack_s = ~a2;
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        dev_nxt = dev_r;
        page_nxt = page_r;
        wd_nxt = wd_r;
        by_nxt = by_r;
        rd_nxt = rd_r;
        dn_nxt = 1'b0;
        to_nxt = 1'b0;
        // page transfer and refresh sampled each tick, held until the next
        pg_nxt = tick ? page_xfer_in : pg_r;      // [R7]
        rf_nxt = tick ? refresh_in : rf_r;        // [R8]
        case (st_r)
            FCB_IDLE: begin
                // only start on a tick so the window is tick aligned;
                // the last ack must have cleared, or a stale one would
                // end the next window at once with old read data
                if (req_valid_in && tick && !ack_s) begin   // [R2] [R12]
                    st_nxt   = FCB_ADDR;
                    cnt_nxt  = '0;
                    wr_nxt   = req_write_in;
                    dev_nxt  = req_dev_in;        // [R3]
                    page_nxt = req_page_in;
                    wd_nxt   = req_wdata_in;
                    by_nxt   = req_bytes_in;
                end
            end
            FCB_ADDR,
            FCB_WAIT: begin
                if (tick) begin
                    cnt_nxt = cnt_r + 1'b1;
                    st_nxt  = FCB_WAIT;
                end
                if (ack_s) begin                  // [R10]
                    st_nxt = FCB_IDLE;
                    dn_nxt = 1'b1;
                    if (!wr_r) begin
                        if (by_r[1])
                            rd_nxt[15:8] = d2[15:8];  // [R9]
                        if (by_r[0])
                            rd_nxt[7:0] = d2[7:0];
                    end
                end else if (tick &&
                    cnt_r == FCB_CNT_W'(FCB_XFER_TICKS - 1)) begin
                    st_nxt = FCB_IDLE;            // [R11]
                    to_nxt = 1'b1;
                end
            end
            default: st_nxt = FCB_IDLE;
        endcase
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= FCB_IDLE;
            cnt_r <= '0;
            wr_r <= 1'b0;
            dev_r <= FCB_RST_DEV;
            page_r <= '0;
            wd_r <= '0;
            by_r <= 2'h0;
            rd_r <= '0;
            dn_r <= 1'b0;
            to_r <= 1'b0;
            pg_r <= 1'b0;
            rf_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            dev_r <= dev_nxt;
            page_r <= page_nxt;
            wd_r <= wd_nxt;
            by_r <= by_nxt;
            rd_r <= rd_nxt;
            dn_r <= dn_nxt;
            to_r <= to_nxt;
            pg_r <= pg_nxt;
            rf_r <= rf_nxt;
        end
    end
    // ------------------------------------------------------------
    // bus drive: address phase held stable for whole window
    // ------------------------------------------------------------
    logic busy;                                   // window open
    assign busy = (st_r != FCB_IDLE);
    assign bus.ctl_bus_valid_strobe  = vstb_r;
    assign bus.ctl_bus_device_select = dev_r;     // [R15]
    assign bus.ctl_bus_page_address  = page_r;
    assign bus.ctl_bus_addr_strobe_n = ~busy;     // [R5]
    assign bus.ctl_bus_write_sel_n   = ~(busy & wr_r);  // [R6]
    assign bus.ctl_bus_upper_byte_n  = ~(busy & by_r[1]);
    assign bus.ctl_bus_lower_byte_n  = ~(busy & by_r[0]);
    assign bus.ctl_bus_page_xfer_n   = ~pg_r;
    assign bus.ctl_bus_refresh_n     = ~rf_r;
    assign bus.m_data    = wd_r;
    assign bus.m_data_oe = busy & wr_r;           // [R1]
    assign req_ready_out = (st_r == FCB_IDLE) & tick & ~ack_s;
    assign done_out      = dn_r;
    assign timeout_out   = to_r;
    assign rdata_out     = rd_r;
endmodule

// ===== hdl/fcb_slave.sv
`timescale 1ns/1ps
module fcb_slave
    import fcb_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  rst_b_in,
    fcb_bus_if.slave                   bus,
    input  wire logic [FCB_DEV_W-1:0]  my_dev_in,
    output logic                       wr_strobe_out,
    output logic [FCB_PAGE_W-1:0]      wr_page_out,
    output logic [FCB_DATA_W-1:0]      wr_data_out,
    output logic [1:0]                 wr_bytes_out,
    output logic                       page_xfer_out,
    output logic                       refresh_out
);
    // ------------------------------------------------------------
    // register file and synchronisers
    // ------------------------------------------------------------
    logic [FCB_DATA_W-1:0] mem [0:(1<<FCB_PAGE_W)-1]; // registers
    // six strobes, device, page and data lanes side by side
    localparam int SNAP_W = 6 + FCB_DEV_W + FCB_PAGE_W + FCB_DATA_W;
    logic [SNAP_W-1:0] s1, s2;     // two-stage sampling of bus
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s1 <= '1;              // idle levels: strobes inactive
            s2 <= '1;
        end else begin
            s1 <= {bus.ctl_bus_addr_strobe_n, bus.ctl_bus_write_sel_n,
                   bus.ctl_bus_upper_byte_n, bus.ctl_bus_lower_byte_n,
                   bus.ctl_bus_page_xfer_n, bus.ctl_bus_refresh_n,
                   bus.ctl_bus_device_select, bus.ctl_bus_page_address,
                   bus.ctl_bus_data[15:0]};
            s2 <= s1;
        end
    end
    logic                  as_n, ws_n, ub_n, lb_n, px_n, rf_n;
    logic [FCB_DEV_W-1:0]  dev;
    logic [FCB_PAGE_W-1:0] pg;
    logic [FCB_DATA_W-1:0] dat;
    assign {as_n, ws_n, ub_n, lb_n, px_n, rf_n, dev, pg, dat} = s2;
    // ------------------------------------------------------------
    // responder: one ack per address strobe
    // ------------------------------------------------------------
    logic                  hit;                     // addressed
    logic                  done_r, done_nxt;        // served flag
    logic                  ack_r, ack_nxt;          // ack drive
    logic                  rd_oe_r, rd_oe_nxt;      // read drive
    logic [FCB_DATA_W-1:0] rdat_r, rdat_nxt;        // read data
    logic                  ws_r, ws_nxt;            // write pulse
    logic [FCB_PAGE_W-1:0] wp_r, wp_nxt;            // write page
    logic [FCB_DATA_W-1:0] wd_r, wd_nxt;            // write data
    logic [1:0]            wb_r, wb_nxt;            // write bytes
    always_comb begin
        hit       = ~as_n && (dev == my_dev_in);    // [R3] [R14]
        done_nxt  = done_r;
        ack_nxt   = ack_r;
        rd_oe_nxt = rd_oe_r;
        rdat_nxt  = rdat_r;
        ws_nxt    = 1'b0;
        wp_nxt    = wp_r;
        wd_nxt    = wd_r;
        wb_nxt    = wb_r;
        if (!hit) begin
            done_nxt  = 1'b0;                       // release drivers
            ack_nxt   = 1'b0;
            rd_oe_nxt = 1'b0;
        end else if (!done_r) begin
            done_nxt = 1'b1;
            ack_nxt  = 1'b1;                        // [R10]
            if (!ws_n) begin                        // [R12]
                ws_nxt = 1'b1;
                wp_nxt = pg;
                wd_nxt = dat;
                wb_nxt = {~ub_n, ~lb_n};            // [R9]
            end else begin
                rd_oe_nxt = 1'b1;                   // [R14]
                rdat_nxt  = mem[pg];
            end
        end
    end
    always_ff @(posedge clock_in) begin
        if (ws_r && wb_r[1])
            mem[wp_r][15:8] <= wd_r[15:8];
        if (ws_r && wb_r[0])
            mem[wp_r][7:0] <= wd_r[7:0];
    end
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            done_r <= 1'b0;
            ack_r <= 1'b0;
            rd_oe_r <= 1'b0;
            rdat_r <= '0;
            ws_r <= 1'b0;
            wp_r <= '0;
            wd_r <= '0;
            wb_r <= 2'h0;
        end else begin
            done_r <= done_nxt;
            ack_r <= ack_nxt;
            rd_oe_r <= rd_oe_nxt;
            rdat_r <= rdat_nxt;
            ws_r <= ws_nxt;
            wp_r <= wp_nxt;
            wd_r <= wd_nxt;
            wb_r <= wb_nxt;
        end
    end
    assign bus.s_ack_n   = ~ack_r;
    assign bus.s_ack_oe  = ack_r;
    assign bus.s_data    = rdat_r;
    assign bus.s_data_oe = rd_oe_r;
    assign wr_strobe_out = ws_r;
    assign wr_page_out   = wp_r;
    assign wr_data_out   = wd_r;
    assign wr_bytes_out  = wb_r;
    assign page_xfer_out = ~px_n;                   // [R7]
    assign refresh_out   = ~rf_n;                   // [R8]
endmodule

// ===== dv/fcb_bus_props.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// wire-level checks between the two ends of the bus
// ------------------------------------------------------------
module fcb_bus_props
    import fcb_pkg::*;
#(
    parameter logic [FCB_DEV_W-1:0] SLAVE_DEV = 6'h00  // id of the slave
)(
    input  wire logic                  clock_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  m_data_oe,
    input  wire logic                  s_data_oe,
    input  wire logic                  s_ack_oe,
    input  wire logic [FCB_DEV_W-1:0]  ctl_bus_device_select,
    input  wire logic [FCB_PAGE_W-1:0] ctl_bus_page_address,
    input  wire logic                  ctl_bus_valid_strobe,
    input  wire logic                  ctl_bus_addr_strobe_n,
    input  wire logic                  ctl_bus_write_sel_n,
    input  wire logic                  ctl_bus_upper_byte_n,
    input  wire logic                  ctl_bus_lower_byte_n,
    input  wire logic                  ctl_bus_ack_n
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    // address phase opens
    sequence s_start;
        $fell(ctl_bus_addr_strobe_n);
    endsequence
    // address phase aimed at the watched slave
    sequence s_mine;
        s_start ##0 (ctl_bus_device_select == SLAVE_DEV);
    endsequence
    // address phase aimed elsewhere
    sequence s_foreign;
        s_start ##0 (ctl_bus_device_select != SLAVE_DEV);
    endsequence

    // address and qualifiers frozen while the strobe is low
    addr_hold_a: assert property (!ctl_bus_addr_strobe_n &&
        $past(ctl_bus_addr_strobe_n) == 1'b0 |->
        $stable(ctl_bus_device_select) && $stable(ctl_bus_page_address) &&
        $stable(ctl_bus_write_sel_n) && $stable(ctl_bus_upper_byte_n) &&
        $stable(ctl_bus_lower_byte_n))
        else $error("address phase changed before completion");
    ack_bound_a: assert property (s_mine |-> ##[1:8] !ctl_bus_ack_n)
        else $error("selected slave did not acknowledge");
    window_end_a: assert property (s_start |->
        ##[1:60] ctl_bus_addr_strobe_n)
        else $error("address strobe outlived the window");
    no_foreign_a: assert property (s_foreign |->
        ##3 (!s_ack_oe && !s_data_oe) [*4])
        else $error("unselected slave drove the bus");
    data_contention_a: assert property (!(m_data_oe && s_data_oe))
        else $error("both ends drive data");
    write_drive_a: assert property (s_start ##0
        !ctl_bus_write_sel_n |-> ##[0:2] m_data_oe)
        else $error("master did not drive write data");
    read_drive_a: assert property (s_data_oe |-> ctl_bus_write_sel_n)
        else $error("slave drove data during a write");
    strobe_rate_a: assert property ($changed(ctl_bus_valid_strobe) |=>
        $stable(ctl_bus_valid_strobe) [*5] ##1 $changed(ctl_bus_valid_strobe))
        else $error("valid strobe period wrong");
    byte_sel_a: assert property (s_start |->
        !(ctl_bus_upper_byte_n && ctl_bus_lower_byte_n))
        else $error("transfer with no byte strobe");
    ack_in_phase_a: assert property ($fell(ctl_bus_ack_n) |->
        !ctl_bus_addr_strobe_n)
        else $error("acknowledge outside address phase");
    ack_release_a: assert property ($rose(ctl_bus_addr_strobe_n) |->
        ##[1:6] (ctl_bus_ack_n && !s_data_oe))
        else $error("slave kept the bus after the phase");
    // a new phase must not open while the last ack still stands
    ack_clear_a: assert property (s_start |-> ctl_bus_ack_n)
        else $error("acknowledge left over from last phase");
endmodule

// ===== dv/front_end_control_bus_bench.sv
`timescale 1ns/1ps
module front_end_control_bus_bench;
    import fcb_pkg::*;
    // ------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ------------------------------------------------------------
    localparam logic [FCB_DEV_W-1:0] DEV_ID = 6'h2a; // slave id, arbitrary
    localparam int LIMIT = 5000;                   // hang ceiling, cycles
    logic                  clock_in     = 1'b0;
    logic                  rst_b_in     = 1'b0;
    logic                  req_valid_in = 1'b0;
    logic                  req_write_in = 1'b0;
    logic [FCB_DEV_W-1:0]  req_dev_in   = 6'h00;
    logic [FCB_PAGE_W-1:0] req_page_in  = 10'h000;
    logic [FCB_DATA_W-1:0] req_wdata_in = 16'h0000;
    logic [1:0]            req_bytes_in = 2'h3;
    logic                  page_xfer_in = 1'b0;
    logic                  refresh_in   = 1'b0;
    logic req_ready_out, done_out, timeout_out, wr_strobe_out;
    logic page_xfer_out, refresh_out;
    logic [FCB_DATA_W-1:0] rdata_out, wr_data_out, wr_data_q;
    logic [FCB_PAGE_W-1:0] wr_page_out, wr_page_q, seen_page;
    logic [1:0]            wr_bytes_out, wr_bytes_q;
    logic [FCB_DEV_W-1:0]  seen_dev;
    logic [2:0]            seen_ctl;  // write sel, upper, lower
    logic                  as_q = 1'b1;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int wr_count = 0;

    always #2 clock_in = ~clock_in;  // 250 MHz

    fcb_bus_if bus_if ();
    fcb_master u_fcb_master (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .bus(bus_if),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .req_write_in(req_write_in), .req_dev_in(req_dev_in),
        .req_page_in(req_page_in), .req_wdata_in(req_wdata_in),
        .req_bytes_in(req_bytes_in), .page_xfer_in(page_xfer_in),
        .refresh_in(refresh_in), .done_out(done_out),
        .timeout_out(timeout_out), .rdata_out(rdata_out));
    fcb_slave u_fcb_slave (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .bus(bus_if),
        .my_dev_in(DEV_ID), .wr_strobe_out(wr_strobe_out),
        .wr_page_out(wr_page_out), .wr_data_out(wr_data_out),
        .wr_bytes_out(wr_bytes_out), .page_xfer_out(page_xfer_out),
        .refresh_out(refresh_out));
    fcb_bus_props #(.SLAVE_DEV(DEV_ID)) u_props (
        .clock_in(clock_in), .rst_b_in(rst_b_in),
        .m_data_oe(bus_if.m_data_oe), .s_data_oe(bus_if.s_data_oe),
        .s_ack_oe(bus_if.s_ack_oe),
        .ctl_bus_device_select(bus_if.ctl_bus_device_select),
        .ctl_bus_page_address(bus_if.ctl_bus_page_address),
        .ctl_bus_valid_strobe(bus_if.ctl_bus_valid_strobe),
        .ctl_bus_addr_strobe_n(bus_if.ctl_bus_addr_strobe_n),
        .ctl_bus_write_sel_n(bus_if.ctl_bus_write_sel_n),
        .ctl_bus_upper_byte_n(bus_if.ctl_bus_upper_byte_n),
        .ctl_bus_lower_byte_n(bus_if.ctl_bus_lower_byte_n),
        .ctl_bus_ack_n(bus_if.ctl_bus_ack_n));

    // wire snapshot at each strobe fall, slave write capture, watchdog
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        as_q   <= bus_if.ctl_bus_addr_strobe_n;
        if (as_q && !bus_if.ctl_bus_addr_strobe_n) begin
            seen_dev  <= bus_if.ctl_bus_device_select;
            seen_page <= bus_if.ctl_bus_page_address;
            seen_ctl  <= {bus_if.ctl_bus_write_sel_n,
                          bus_if.ctl_bus_upper_byte_n,
                          bus_if.ctl_bus_lower_byte_n};
        end
        if (wr_strobe_out === 1'b1) begin
            wr_count   <= wr_count + 1;
            wr_page_q  <= wr_page_out;
            wr_data_q  <= wr_data_out;
            wr_bytes_q <= wr_bytes_out;
        end
        if (cycles == LIMIT) begin
            summarize();                 // hang counted there
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one transfer; how = {timeout, done}, lat = cycles after take
    task automatic xfer(input logic wr, input logic [FCB_DEV_W-1:0] dev,
                        input logic [FCB_PAGE_W-1:0] page,
                        input logic [FCB_DATA_W-1:0] data,
                        input logic [1:0] bytes, output logic [1:0] how,
                        output int lat);
        int n;
        n   = 0;
        lat = 0;
        @(posedge clock_in);
        req_write_in <= wr;
        req_dev_in   <= dev;
        req_page_in  <= page;
        req_wdata_in <= data;
        req_bytes_in <= bytes;
        req_valid_in <= 1'b1;
        @(negedge clock_in);
        while (req_ready_out !== 1'b1 && n < 50) begin
            @(negedge clock_in);
            n++;
        end
        @(posedge clock_in);
        req_valid_in <= 1'b0;
        @(negedge clock_in);
        check("busy ready", req_ready_out, 1'b0);
        while (done_out !== 1'b1 && timeout_out !== 1'b1 && lat < 80) begin
            @(negedge clock_in);
            lat++;
        end
        how = {timeout_out, done_out};
        // slave release and read data settle well within this
        repeat (8) @(negedge clock_in);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_full();
        logic [1:0] how;
        int         lat;
        int         wc;
        wc = wr_count;
        xfer(1'b1, DEV_ID, 10'h3ff, 16'hbeef, 2'h3, how, lat);
        check("write status", how, 2'h1);
        check("write time", lat <= 8 * FCB_SYS_DIV, 1);
        check("write count", wr_count, wc + 1);
        check("write page", wr_page_q, 10'h3ff);
        check("write data", wr_data_q, 16'hbeef);
        check("bus device", seen_dev, DEV_ID);
        check("bus page", seen_page, 10'h3ff);
        check("bus write ctl", seen_ctl, 3'b000);
        xfer(1'b0, DEV_ID, 10'h3ff, 16'h0000, 2'h3, how, lat);
        check("read status", how, 2'h1);
        check("bus read ctl", seen_ctl, 3'b100);
        check("read data", rdata_out, 16'hbeef);
    endtask

    // lone byte write must leave the other byte untouched
    task automatic t_bytes(input logic [1:0] b);
        logic [1:0]  how;
        int          lat;
        logic [15:0] exp;
        exp = {b[1] ? 8'hab : 8'h12, b[0] ? 8'hcd : 8'h34};
        xfer(1'b1, DEV_ID, 10'h000, 16'h1234, 2'h3, how, lat);
        xfer(1'b1, DEV_ID, 10'h000, 16'habcd, b, how, lat);
        check("bus byte strobes", seen_ctl[1:0], 2'(~b));
        check("slave bytes", wr_bytes_q, b);
        xfer(1'b0, DEV_ID, 10'h000, 16'h0000, 2'h3, how, lat);
        check("byte merge", rdata_out, exp);
    endtask

    // nobody answers: window closes, slave stays quiet
    task automatic t_other();
        logic [1:0] how;
        int         lat;
        int         wc;
        wc = wr_count;
        xfer(1'b1, 6'h15, 10'h155, 16'h5a5a, 2'h3, how, lat);
        check("foreign status", how, 2'h2);
        check("foreign window", lat >= 40 && lat <= 56, 1);
        check("foreign count", wr_count, wc);
    endtask

    // sel 1 drives refresh, sel 0 page transfer
    task automatic t_side(input logic sel);
        @(posedge clock_in);
        if (sel) begin
            refresh_in <= 1'b1;
        end else begin
            page_xfer_in <= 1'b1;
        end
        repeat (20) @(negedge clock_in);
        check("side wire", sel ? bus_if.ctl_bus_refresh_n :
              bus_if.ctl_bus_page_xfer_n, 1'b0);
        check("side out", sel ? refresh_out : page_xfer_out,
              1'b1);
        check("side other", sel ? page_xfer_out : refresh_out,
              1'b0);
        @(posedge clock_in);
        refresh_in   <= 1'b0;
        page_xfer_in <= 1'b0;
        repeat (20) @(negedge clock_in);
        check("side idle", {bus_if.ctl_bus_refresh_n,
              bus_if.ctl_bus_page_xfer_n, refresh_out, page_xfer_out},
              4'b1100);
    endtask

    task automatic summarize();
        // reaching the cycle ceiling means something hung
        if (cycles >= LIMIT) begin
            errors++;
        end
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock_in);
        rst_b_in <= 1'b1;
        t_full();
        t_bytes(2'b10);
        t_bytes(2'b01);
        t_other();
        t_side(1'b0);
        t_side(1'b1);
        summarize();
    end
endmodule
